//--- core/hbm_pkg.sv
// Shared types and constants for the host bus mode selection block.
// Assumes one 100 MHz clock and a synchronous, active-high reset.
package hbm_pkg;

  // ************************************************************
  // Bus personalities and access widths
  // ************************************************************
  typedef enum logic [2:0] {
    HBM_MODE_PCI    = 3'b000,
    HBM_MODE_ISA    = 3'b001,
    HBM_MODE_PCMCIA = 3'b010,
    HBM_MODE_PAR    = 3'b011,
    HBM_MODE_SPI    = 3'b100
  } hbm_mode_e;

  typedef enum logic [1:0] {
    HBM_W8  = 2'b00,
    HBM_W16 = 2'b01,
    HBM_W32 = 2'b10
  } hbm_width_e;

  // Parallel sub-modes: strobe with direction, flat, multiplexed
  typedef enum logic [1:0] {
    HBM_PAR_RW_STROBE = 2'b00,
    HBM_PAR_RDWR_FLAT = 2'b01,
    HBM_PAR_RDWR_MUX  = 2'b10
  } hbm_par_e;

  // Serial clock detection states
  typedef enum logic [1:0] {
    HBM_DET_RESET  = 2'b00,
    HBM_DET_WATCH  = 2'b01,
    HBM_DET_LOCKED = 2'b10
  } hbm_det_e;

  // ************************************************************
  // Register request carrier
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hbm_reg_req_s;

  // ************************************************************
  // Strap codes, written as {high strap, low strap}
  // ************************************************************
  localparam logic [1:0] HBM_STRAP_PCI = 2'b00;
  localparam logic [1:0] HBM_STRAP_ISA = 2'b10;
  localparam logic [1:0] HBM_STRAP_PCMCIA = 2'b11;
  localparam logic [1:0] HBM_STRAP_PAR = 2'b01;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] HBM_OFS_CIRM = 8'h00;
  localparam logic [7:0] HBM_OFS_CTRL = 8'h01;
  localparam logic [7:0] HBM_OFS_RAM_LO = 8'h08;
  localparam logic [7:0] HBM_OFS_RAM_MID = 8'h09;
  localparam logic [7:0] HBM_OFS_RAM_HI = 8'h0A;
  localparam logic [7:0] HBM_OFS_RAM_MISC = 8'h0C;
  localparam logic [7:0] HBM_OFS_RAM_USE = 8'h15;
  localparam logic [7:0] HBM_OFS_CHIP_ID = 8'h16;
  localparam logic [7:0] HBM_OFS_STATUS = 8'h1C;
  localparam logic [7:0] HBM_OFS_CHIP_RV = 8'h1F;
  localparam logic [7:0] HBM_OFS_GPIO_SEL0 = 8'h40;
  localparam logic [7:0] HBM_OFS_GPIO_SEL1 = 8'h41;
  localparam logic [7:0] HBM_OFS_GPIO_OE0 = 8'h42;
  localparam logic [7:0] HBM_OFS_GPIO_OE1 = 8'h43;
  localparam logic [7:0] HBM_OFS_GPIO_OUT0 = 8'h44;
  localparam logic [7:0] HBM_OFS_GPIO_OUT1 = 8'h45;
  localparam logic [7:0] HBM_OFS_GPIO_IN0 = 8'h48;
  localparam logic [7:0] HBM_OFS_GPIO_IN1 = 8'h49;
  localparam logic [7:0] HBM_OFS_GPI_IN0 = 8'h4A;
  localparam logic [7:0] HBM_OFS_GPI_IN1 = 8'h4B;
  localparam logic [7:0] HBM_OFS_GPI_IN2 = 8'h4C;
  localparam logic [7:0] HBM_OFS_GPI_IN3 = 8'h4D;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int HBM_CTRL_SUB_MSB = 1;
  localparam int HBM_CTRL_SUB_LSB = 0;
  localparam int HBM_STAT_MODE_MSB = 2;
  localparam int HBM_STAT_MODE_LSB = 0;
  localparam int HBM_STAT_LOCK = 3;
  localparam logic [7:0] HBM_BYTE_RST = 8'h00;
  localparam logic [15:0] HBM_HALF_RST = 16'h0000;
  localparam logic [31:0] HBM_WORD_RST = 32'h0000_0000;

  // ************************************************************
  // Pin counts
  // ************************************************************
  localparam int HBM_TX_PINS = 16;
  localparam int HBM_GPI_PINS = 32;

endpackage

//--- core/hbm_gpio_cell.sv
// One shared transmit / general-purpose pin cell.
// Assumes the pad input is synchronous to mclk.
`timescale 1ns/1ps
module hbm_gpio_cell (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Selection and data from the register file
  input wire logic use_gpio,
  input wire logic gpio_drive,
  input wire logic gpio_value,
  // Line transmit data
  input wire logic line_tx,
  // Pad signals
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe,
  output logic gpio_sample
);
  import hbm_pkg::*;

  // ************************************************************
  // Output path
  // ************************************************************
  // Transmit drives always; general-purpose drives when enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      pad_o <= 1'b0;
      pad_oe <= 1'b0;
    end else if (use_gpio) begin
      pad_o <= gpio_value;
      pad_oe <= gpio_drive;
    end else begin
      pad_o <= line_tx;
      pad_oe <= 1'b1;
    end
  end

  // ************************************************************
  // Input path
  // ************************************************************
  // Pad level as seen by software
  always_ff @(posedge mclk) begin
    if (rst) begin
      gpio_sample <= 1'b0;
    end else begin
      gpio_sample <= pad_i;
    end
  end

endmodule

//--- core/hbm_mode_select.sv
// Host bus mode selection and shared pin multiplexer.
// Assumes all pin inputs are synchronous to mclk and that rst is
// synchronous, active high and held while the straps are valid.
`timescale 1ns/1ps
module hbm_mode_select #(
  parameter logic [7:0] CHIP_ID_VALUE = 8'h5A, // Arbitrary value
  parameter logic [7:0] CHIP_REV_VALUE = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Mode straps
  input wire logic bus_strap_lo,
  input wire logic bus_strap_hi,
  // Mode-dependent pins
  input wire logic serial_clock_in,
  input wire logic serial_select_n,
  input wire logic pin195_i,
  output logic pin196_o,
  output logic pin196_oe,
  input wire logic [3:0] upper_addr_pins,
  // Interrupt pin, open drain
  output logic irq_pin_o,
  output logic irq_pin_oe,
  // Mode flags
  output hbm_pkg::hbm_mode_e bus_mode,
  output logic mode_locked,
  output logic mode_dependent_supply,
  output logic [1:0] mode_dependent_ground,
  output logic tie_low_input,
  output logic [3:0] upper_addr,
  // Core requests
  input wire logic irq_req,
  input wire logic pme_req,
  input wire logic serial_tx_data,
  input wire logic par_strobe,
  output logic power_event_in,
  output logic serial_rx_data,
  output logic serial_selected,
  output logic serial_clock,
  // Access width check
  input wire logic acc_req,
  input wire hbm_pkg::hbm_width_e acc_width,
  output logic acc_ok,
  // Register port
  input wire hbm_pkg::hbm_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // Line transmit pins and general-purpose I/O
  input wire logic [15:0] line_tx_a,
  input wire logic [15:0] general_io_pin_i,
  output logic [15:0] general_io_pin_o,
  output logic [15:0] general_io_pin_oe,
  // Line receive and level-detect pins, general inputs
  input wire logic [31:0] general_input_pin,
  output logic [31:0] line_rx_a
);
  import hbm_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [1:0] strap_reg; // Straps caught during reset
  hbm_det_e det_reg; // Serial clock detector state
  hbm_det_e det_next;
  logic spi_reg; // Serial personality found
  logic clk_prev_reg; // Last bus clock pin level
  logic clk_edge; // Rising edge on the bus clock pin
  hbm_mode_e mode_next;
  logic [7:0] cirm_reg; // Chip reset and misc byte
  logic [7:0] ctrl_reg; // Bus control byte
  logic [23:0] ram_addr_reg; // RAM address bytes
  logic [7:0] ram_misc_reg; // RAM misc byte
  logic [15:0] gpio_sel_reg; // Per pin general-purpose select
  logic [15:0] gpio_oe_reg; // Per pin drive enable
  logic [15:0] gpio_out_reg; // Per pin output value
  logic [15:0] gpio_in; // Sampled pad levels
  logic [31:0] gpi_reg; // Sampled general inputs
  hbm_par_e par_sub; // Parallel sub-mode
  logic [7:0] rdata_next;

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Straps follow the pins in reset, then stay frozen
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_reg <= {bus_strap_hi, bus_strap_lo};
    end
  end

  // ************************************************************
  // Serial clock detection
  // ************************************************************
  // Bus clock pin history for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= serial_clock_in;
    end
  end

  assign clk_edge = serial_clock_in & ~clk_prev_reg;

  // Next detector state
  always_comb begin
    det_next = det_reg;
    case (det_reg)
      HBM_DET_RESET: begin
        // Only parallel straps need watching
        if (strap_reg == HBM_STRAP_PAR) begin
          det_next = HBM_DET_WATCH;
        end else begin
          det_next = HBM_DET_LOCKED;
        end
      end
      HBM_DET_WATCH: begin
        // Clock edge or a parallel strobe settles it
        if (clk_edge || par_strobe) begin
          det_next = HBM_DET_LOCKED;
        end
      end
      HBM_DET_LOCKED: begin
        det_next = HBM_DET_LOCKED;
      end
      default: begin
        det_next = HBM_DET_RESET;
      end
    endcase
  end

  // Detector state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      det_reg <= HBM_DET_RESET;
    end else begin
      det_reg <= det_next;
    end
  end

  // Serial flag: clock edge before or in the same cycle as the first parallel strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_reg <= 1'b0;
    end else if (det_reg == HBM_DET_WATCH && clk_edge) begin
      spi_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  // Strap code to personality
  always_comb begin
    case (strap_reg)
      HBM_STRAP_PCI: mode_next = HBM_MODE_PCI;
      HBM_STRAP_ISA: mode_next = HBM_MODE_ISA;
      HBM_STRAP_PCMCIA: mode_next = HBM_MODE_PCMCIA;
      HBM_STRAP_PAR: begin
        mode_next = spi_reg ? HBM_MODE_SPI : HBM_MODE_PAR;
      end
      default: mode_next = HBM_MODE_PCI;
    endcase
  end

  // Personality and lock flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_mode <= HBM_MODE_PCI;
      mode_locked <= 1'b0;
    end else begin
      bus_mode <= mode_next;
      mode_locked <= (det_reg == HBM_DET_LOCKED);
    end
  end

  // ************************************************************
  // Access width check
  // ************************************************************
  assign par_sub = hbm_par_e'(ctrl_reg[HBM_CTRL_SUB_MSB:HBM_CTRL_SUB_LSB]);

  // Width allowed in the current personality
  always_comb begin
    acc_ok = 1'b0;
    if (acc_req) begin
      case (bus_mode)
        HBM_MODE_PCI: acc_ok = (acc_width != 2'b11);
        HBM_MODE_ISA, HBM_MODE_PCMCIA: begin
          acc_ok = (acc_width == HBM_W8) || (acc_width == HBM_W16);
        end
        HBM_MODE_PAR: begin
          if (par_sub == HBM_PAR_RDWR_MUX) begin
            acc_ok = (acc_width != 2'b11);
          end else begin
            acc_ok = (acc_width == HBM_W8) || (acc_width == HBM_W16);
          end
        end
        HBM_MODE_SPI: acc_ok = (acc_width == HBM_W8);
        default: acc_ok = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Shared pin functions
  // ************************************************************
  // Serial, power event and address pins by personality
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_selected <= 1'b0;
      serial_rx_data <= 1'b0;
      serial_clock <= 1'b0;
      power_event_in <= 1'b0;
      pin196_o <= 1'b0;
      pin196_oe <= 1'b0;
      upper_addr <= 4'h0;
    end else begin
      serial_selected <= (bus_mode == HBM_MODE_SPI) & ~serial_select_n;
      serial_rx_data <= (bus_mode == HBM_MODE_SPI) & pin195_i;
      serial_clock <= (bus_mode == HBM_MODE_SPI) & serial_clock_in;
      power_event_in <= (bus_mode == HBM_MODE_PCI) & pin195_i;
      upper_addr <= (bus_mode == HBM_MODE_ISA) ? upper_addr_pins : 4'h0;
      case (bus_mode)
        HBM_MODE_SPI: begin
          pin196_o <= serial_tx_data;
          pin196_oe <= 1'b1;
        end
        HBM_MODE_PCI: begin
          pin196_o <= pme_req;
          pin196_oe <= 1'b1;
        end
        default: begin
          pin196_o <= 1'b0;
          pin196_oe <= 1'b0;
        end
      endcase
    end
  end

  // Flags telling which shared pins are plain ground or supply
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_dependent_supply <= 1'b1;
      mode_dependent_ground <= 2'b00;
      tie_low_input <= 1'b0;
    end else begin
      mode_dependent_supply <= (bus_mode != HBM_MODE_SPI);
      mode_dependent_ground[0] <= (bus_mode == HBM_MODE_ISA) ||
        (bus_mode == HBM_MODE_PAR);
      mode_dependent_ground[1] <= (bus_mode != HBM_MODE_PCI) &&
        (bus_mode != HBM_MODE_SPI) && (bus_mode != HBM_MODE_PCMCIA);
      tie_low_input <= (bus_mode == HBM_MODE_PAR) ||
        (bus_mode == HBM_MODE_SPI);
    end
  end

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  // Pull low only; released in ISA and PCMCIA
  assign irq_pin_o = 1'b0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pin_oe <= 1'b0;
    end else begin
      irq_pin_oe <= irq_req && ((bus_mode == HBM_MODE_PCI) ||
        (bus_mode == HBM_MODE_PAR) || (bus_mode == HBM_MODE_SPI));
    end
  end

  // ************************************************************
  // General-purpose pins
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < HBM_TX_PINS; gi++) begin : g_cell
      hbm_gpio_cell u_cell (
        .mclk(mclk),
        .rst(rst),
        .use_gpio(gpio_sel_reg[gi]),
        .gpio_drive(gpio_oe_reg[gi]),
        .gpio_value(gpio_out_reg[gi]),
        .line_tx(line_tx_a[gi]),
        .pad_i(general_io_pin_i[gi]),
        .pad_o(general_io_pin_o[gi]),
        .pad_oe(general_io_pin_oe[gi]),
        .gpio_sample(gpio_in[gi])
      );
    end
  endgenerate

  // Receive pins feed the line side and software alike
  always_ff @(posedge mclk) begin
    if (rst) begin
      gpi_reg <= HBM_WORD_RST;
      line_rx_a <= HBM_WORD_RST;
    end else begin
      gpi_reg <= general_input_pin;
      line_rx_a <= general_input_pin;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  // Write-only bytes and general-purpose controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      cirm_reg <= HBM_BYTE_RST;
      ctrl_reg <= HBM_BYTE_RST;
      ram_addr_reg <= {HBM_BYTE_RST, HBM_BYTE_RST, HBM_BYTE_RST};
      ram_misc_reg <= HBM_BYTE_RST;
      gpio_sel_reg <= HBM_HALF_RST;
      gpio_oe_reg <= HBM_HALF_RST;
      gpio_out_reg <= HBM_HALF_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        HBM_OFS_CIRM: cirm_reg <= reg_req.wdata;
        HBM_OFS_CTRL: ctrl_reg <= reg_req.wdata;
        HBM_OFS_RAM_LO: ram_addr_reg[7:0] <= reg_req.wdata;
        HBM_OFS_RAM_MID: ram_addr_reg[15:8] <= reg_req.wdata;
        HBM_OFS_RAM_HI: ram_addr_reg[23:16] <= reg_req.wdata;
        HBM_OFS_RAM_MISC: ram_misc_reg <= reg_req.wdata;
        HBM_OFS_GPIO_SEL0: gpio_sel_reg[7:0] <= reg_req.wdata;
        HBM_OFS_GPIO_SEL1: gpio_sel_reg[15:8] <= reg_req.wdata;
        HBM_OFS_GPIO_OE0: gpio_oe_reg[7:0] <= reg_req.wdata;
        HBM_OFS_GPIO_OE1: gpio_oe_reg[15:8] <= reg_req.wdata;
        HBM_OFS_GPIO_OUT0: gpio_out_reg[7:0] <= reg_req.wdata;
        HBM_OFS_GPIO_OUT1: gpio_out_reg[15:8] <= reg_req.wdata;
        default: begin
          // Unmapped or read-only offsets ignore writes
        end
      endcase
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  // Read mux; write-only and unmapped offsets give zero
  always_comb begin
    rdata_next = HBM_BYTE_RST;
    case (reg_req.addr)
      HBM_OFS_RAM_USE: rdata_next = HBM_BYTE_RST;
      HBM_OFS_CHIP_ID: rdata_next = CHIP_ID_VALUE;
      HBM_OFS_STATUS: begin
        rdata_next[HBM_STAT_MODE_MSB:HBM_STAT_MODE_LSB] = bus_mode;
        rdata_next[HBM_STAT_LOCK] = mode_locked;
      end
      HBM_OFS_CHIP_RV: rdata_next = CHIP_REV_VALUE;
      HBM_OFS_GPIO_IN0: rdata_next = gpio_in[7:0];
      HBM_OFS_GPIO_IN1: rdata_next = gpio_in[15:8];
      HBM_OFS_GPI_IN0: rdata_next = gpi_reg[7:0];
      HBM_OFS_GPI_IN1: rdata_next = gpi_reg[15:8];
      HBM_OFS_GPI_IN2: rdata_next = gpi_reg[23:16];
      HBM_OFS_GPI_IN3: rdata_next = gpi_reg[31:24];
      default: rdata_next = HBM_BYTE_RST;
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= HBM_BYTE_RST;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

//--- bench/hbm_host_model.sv
// Host side model driving the serial select and serial clock pins.
// Assumes the bench raises frame on a falling edge of mclk.
`timescale 1ns/1ps
module hbm_host_model (
  // Clock and frame request
  input wire logic mclk,
  input wire logic frame,
  // Serial pins toward the device
  // Idle: clock stands low, select released high
  output logic serial_clock_in = 1'b0,
  output logic serial_select_n = 1'b1
);
  // ************************************************************
  // Serial frame driver
  // ************************************************************
  // Clock toggles each falling edge only inside a frame
  always @(negedge mclk) begin
    serial_select_n <= !frame;
    serial_clock_in <= frame ? !serial_clock_in : 1'b0;
  end
endmodule

//--- bench/hbm_mode_select_assertions.sv
// Checker on the ports of the mode selection block.
// Assumes one clock mclk and synchronous active-high rst.
`timescale 1ns/1ps
module hbm_mode_select_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched signals
  input wire hbm_pkg::hbm_mode_e bus_mode,
  input wire logic mode_locked,
  input wire logic acc_req,
  input wire hbm_pkg::hbm_width_e acc_width,
  input wire logic acc_ok,
  input wire logic irq_req,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  input wire logic mode_dependent_supply,
  input wire logic pin195_i,
  input wire logic serial_rx_data,
  input wire logic serial_select_n,
  input wire logic serial_selected,
  input wire logic [31:0] general_input_pin,
  input wire logic [31:0] line_rx_a
);
  import hbm_pkg::*;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_w_idle; !acc_req |-> !acc_ok; endproperty
  a_w_idle: assert property (p_w_idle) else $error("width ok idle");
  property p_w_spi;
    acc_req && bus_mode == HBM_MODE_SPI && acc_width != HBM_W8 |-> !acc_ok;
  endproperty
  a_w_spi: assert property (p_w_spi) else $error("wide spi ok");
  property p_w_pci;
    acc_req && bus_mode == HBM_MODE_PCI && acc_width != 2'b11 |-> acc_ok;
  endproperty
  a_w_pci: assert property (p_w_pci) else $error("pci width refused");
  property p_irq_off;
    bus_mode inside {HBM_MODE_ISA, HBM_MODE_PCMCIA} |=> !irq_pin_oe;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq driven");
  property p_irq_on;
    irq_req && bus_mode == HBM_MODE_PCI |=> irq_pin_oe && !irq_pin_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not pulled");
  property p_lock; mode_locked |=> $stable(bus_mode) && mode_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("mode moved");
  property p_supply;
    1'b1 |=> mode_dependent_supply == ($past(bus_mode) != HBM_MODE_SPI);
  endproperty
  a_supply: assert property (p_supply) else $error("supply flag");
  property p_rx;
    bus_mode == HBM_MODE_SPI |=> serial_rx_data == $past(pin195_i);
  endproperty
  a_rx: assert property (p_rx) else $error("serial rx");
  property p_sel;
    bus_mode == HBM_MODE_SPI |=> serial_selected == !$past(serial_select_n);
  endproperty
  a_sel: assert property (p_sel) else $error("serial select");
  property p_gpi; 1'b1 |=> line_rx_a == $past(general_input_pin);
  endproperty
  a_gpi: assert property (p_gpi) else $error("rx copy");
endmodule
bind hbm_mode_select hbm_mode_select_assertions i_hbm_mode_select_assertions (
  .mclk(mclk), .rst(rst), .bus_mode(bus_mode), .mode_locked(mode_locked),
  .acc_req(acc_req), .acc_width(acc_width), .acc_ok(acc_ok),
  .irq_req(irq_req), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
  .mode_dependent_supply(mode_dependent_supply), .pin195_i(pin195_i),
  .serial_rx_data(serial_rx_data), .serial_select_n(serial_select_n),
  .serial_selected(serial_selected),
  .general_input_pin(general_input_pin), .line_rx_a(line_rx_a));

//--- bench/tb.sv
// Testbench for the mode selection block and its register port.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module tb;
  import hbm_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic mclk = 0, rst = 1, bus_strap_lo = 0, bus_strap_hi = 0, frame = 0;
  logic par_strobe = 0, acc_req = 0, pin195_i = 1, irq_req = 1;
  logic serial_clock_in, serial_select_n, irq_pin_o, irq_pin_oe;
  logic mode_locked, supply, tie, pev, srx, ssel, sclk, acc_ok, p6o, p6oe;
  logic [1:0] gnd;
  logic [3:0] upper_addr;
  logic [7:0] reg_rdata;
  logic [15:0] line_tx_a = 16'hA5C3, gin = 16'h3C96, go, goe;
  logic [31:0] gpi = 32'h1234_5678, line_rx_a;
  hbm_mode_e bus_mode;
  hbm_width_e acc_width = HBM_W8;
  hbm_reg_req_s rq = '0;
  int num_errors = 0, comparisons = 0;
  // Strap codes and allowed widths (bit = width code) per mode
  logic [1:0] strap [5] = '{2'b00, 2'b10, 2'b11, 2'b01, 2'b01};
  logic [3:0] wexp [5] = '{4'h7, 4'h3, 4'h3, 4'h3, 4'h1};
  // 10 ns clock
  always #5 mclk = !mclk;
  hbm_host_model i_hbm_host_model (.mclk(mclk), .frame(frame),
    .serial_clock_in(serial_clock_in), .serial_select_n(serial_select_n));
  hbm_mode_select #(.CHIP_ID_VALUE(8'h3E), .CHIP_REV_VALUE(8'h07))
  i_hbm_mode_select (.mclk(mclk), .rst(rst), .bus_strap_lo(bus_strap_lo),
    .bus_strap_hi(bus_strap_hi), .serial_clock_in(serial_clock_in),
    .serial_select_n(serial_select_n), .pin195_i(pin195_i),
    .pin196_o(p6o), .pin196_oe(p6oe), .upper_addr_pins(4'hA),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .bus_mode(bus_mode),
    .mode_locked(mode_locked), .mode_dependent_supply(supply),
    .mode_dependent_ground(gnd), .tie_low_input(tie),
    .upper_addr(upper_addr), .irq_req(irq_req), .pme_req(1'b0),
    .serial_tx_data(1'b1), .par_strobe(par_strobe), .power_event_in(pev),
    .serial_rx_data(srx), .serial_selected(ssel), .serial_clock(sclk),
    .acc_req(acc_req), .acc_width(acc_width), .acc_ok(acc_ok),
    .reg_req(rq), .reg_rdata(reg_rdata), .line_tx_a(line_tx_a),
    .general_io_pin_i(gin), .general_io_pin_o(go),
    .general_io_pin_oe(goe), .general_input_pin(gpi),
    .line_rx_a(line_rx_a));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Compare one value, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) rq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk) rq = '0;
  endtask
  // Register read, data checked a cycle and a half after the taking edge
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk) rq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk) rq = '0;
    @(negedge mclk) chk(reg_rdata, exp);
  endtask
  // Verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  // Watchdog, far beyond the about 160 cycles needed
  initial begin
    #50us;
    num_errors++;
    final_report();
  end
  initial begin
    for (int m = 0; m < 5; m++) begin
      // Reset 4 cycles with the straps of this mode
      @(negedge mclk) rst = 1;
      {bus_strap_hi, bus_strap_lo} = strap[m];
      repeat (4) @(negedge mclk);
      rst = 0;
      repeat (3) @(negedge mclk);
      {bus_strap_hi, bus_strap_lo} = ~strap[m];
      par_strobe = (m == 3);
      frame = (m == 4);
      @(negedge mclk) par_strobe = 0;
      repeat (5) @(negedge mclk);
      reg_rd(HBM_OFS_STATUS, {4'h0, 1'b1, 3'(m)});
      chk(irq_pin_oe, m == 0 || m >= 3);
      chk(supply, m != 4);
      chk(gnd, (m == 1 || m == 3) ? 2'b11 : 2'b00);
      chk(tie, m >= 3);
      chk(upper_addr, (m == 1) ? 4'hA : 4'h0);
      chk(p6oe, m == 0 || m == 4);
      if (p6oe === 1'b1) chk(p6o, m == 4);
      chk(pev, m == 0);
      chk({srx, ssel}, (m == 4) ? 2'b11 : 2'b00);
      for (int w = 0; w < 4; w++) begin
        @(negedge mclk) acc_req = 1;
        acc_width = hbm_width_e'(w);
        #1 chk(acc_ok, wexp[m][w]);
      end
      if (m == 3) begin
        // Flat sub-mode keeps 32 bit refused, multiplexed allows it
        reg_wr(HBM_OFS_CTRL, 8'h01);
        @(negedge mclk) acc_width = HBM_W32;
        #1 chk(acc_ok, 1'b0);
        reg_wr(HBM_OFS_CTRL, 8'h02);
        @(negedge mclk) acc_width = HBM_W32;
        #1 chk(acc_ok, 1'b1);
      end
      @(negedge mclk) acc_req = 0;
      #1 chk(acc_ok, 1'b0);
      // Serial clock copy lags the pin, which toggled this edge
      chk(sclk, (m == 4) ? !serial_clock_in : 1'b0);
      frame = 0;
    end
    // Shared pins: line data by default, then low nibble as GPIO
    chk({go, goe}, {16'hA5C3, 16'hFFFF});
    // Interrupt request withdrawn: pin must be released
    irq_req = 0;
    reg_wr(HBM_OFS_GPIO_SEL0, 8'h0F);
    reg_wr(HBM_OFS_GPIO_OE0, 8'h05);
    reg_wr(HBM_OFS_GPIO_OUT0, 8'h0C);
    repeat (2) @(negedge mclk);
    chk(irq_pin_oe, 1'b0);
    chk({go, goe}, {16'hA5CC, 16'hFFF5});
    reg_rd(HBM_OFS_GPIO_IN0, 8'h96);
    gpi = 32'h8765_4321;
    for (int b = 0; b < 4; b++)
      reg_rd(HBM_OFS_GPI_IN0 + 8'(b), gpi[8*b +: 8]);
    chk(line_rx_a, gpi);
    // Fixed, write-only, unmapped and read-only places
    reg_rd(HBM_OFS_CHIP_ID, 8'h3E);
    reg_rd(HBM_OFS_CHIP_RV, 8'h07);
    reg_rd(HBM_OFS_RAM_USE, 8'h00);
    reg_rd(HBM_OFS_CIRM, 8'h00);
    reg_rd(8'h7F, 8'h00);
    reg_wr(HBM_OFS_STATUS, 8'hFF);
    reg_rd(HBM_OFS_STATUS, 8'h0C);
    final_report();
  end
endmodule
